// >>> design/hsc_pkg_sync.sv
// Shared package for the homing block and its switch input synchroniser
`timescale 1ns/1ps
`default_nettype none

package hsc_pkg;
	// Direction encoding on the dir output
	localparam logic DIR_POS = 1'b1;
	localparam logic DIR_NEG = 1'b0;
	// Selective clear argument codes and field positions
	localparam logic [1:0] CLR_POS = 2'h1;
	localparam logic [1:0] CLR_OUT = 2'h2;
	localparam logic [1:0] CLR_BOTH = 2'h3;
	localparam int CLR_POS_BIT = 0;
	localparam int CLR_OUT_BIT = 1;
	// Program words taken by a stored selective clear
	localparam logic [1:0] STORE_WORDS = 2'h2;
	// Switch level seen while the synchroniser is in reset (inactive)
	localparam logic [1:0] SW_RESET = 2'h3;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_SEEK_EOT = 2'b01,
		ST_SEEK_HOME = 2'b10,
		ST_FINISH = 2'b11
	} hsc_state_type;

	// One command from the host parser or the program sequencer
	typedef struct packed {
		logic home;
		logic dir_given;
		logic dir_neg;
		logic [1:0] clear_sel;
		logic store;
	} hsc_cmd_type;

	// Request to write a selective clear into program memory
	typedef struct packed {
		logic valid;
		logic [1:0] clear_sel;
		logic [1:0] words;
	} hsc_store_type;
endpackage

// Two-stage synchroniser for the end-of-travel and home switches
module hsc_sync (
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic [1:0] din,
	output logic [1:0] dout
);
	logic [1:0] meta;

	// First stage feeds only the second; switches idle high so reset to high
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			meta <= hsc_pkg::SW_RESET;
			dout <= hsc_pkg::SW_RESET;
		end else begin
			meta <= din;
			dout <= meta;
		end
	end
endmodule

`default_nettype wire

// >>> design/hsc_homing.sv
// Homing sequence and selective clear command logic of the motor controller
`timescale 1ns/1ps
`default_nettype none

module hsc_homing (
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic extended,
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire hsc_pkg::hsc_cmd_type cmd,
	input wire logic prog_recalled,
	input wire logic rxd_tied_high,
	input wire logic step_tick,
	input wire logic eot_n,
	input wire logic home_n,
	output logic busy,
	output logic step,
	output logic dir,
	output logic pos_clear,
	output logic out_clear,
	output logic prog_clear,
	output hsc_pkg::hsc_store_type store
);
	hsc_pkg::hsc_state_type state, next_state;
	logic next_busy, next_step, next_dir;
	logic next_pos_clear, next_out_clear, next_prog_clear;
	hsc_pkg::hsc_store_type next_store;
	logic auto_pend, next_auto_pend;
	logic auto_neg, next_auto_neg;
	logic [1:0] sw_sync;
	logic eot_low, home_low, accept;

	// Bit test on the clear argument, shared by both clear targets
	function automatic logic clear_hit(input logic [1:0] sel, input int bitpos);
		clear_hit = sel[bitpos];
	endfunction

	// Switches are only looked at after two flops
	hsc_sync u_sync (
		.mclk(mclk),
		.arst_n(arst_n),
		.din({home_n, eot_n}),
		.dout(sw_sync)
	);
	assign eot_low = !sw_sync[0];
	assign home_low = !sw_sync[1];

	// A pending start-up homing holds off host commands until it has run
	assign cmd_ready = (state == hsc_pkg::ST_IDLE) && !auto_pend;
	assign accept = cmd_valid && cmd_ready;

	// Sequencer next state and one-cycle output pulses
	always_comb begin
		next_state = state;
		next_busy = busy;
		next_step = 1'b0;
		next_dir = dir;
		next_pos_clear = 1'b0;
		next_out_clear = 1'b0;
		next_prog_clear = 1'b0;
		next_store = '0;
		next_auto_pend = auto_pend;
		next_auto_neg = auto_neg;
		unique case (state)
			hsc_pkg::ST_IDLE: begin
				if (auto_pend) begin
					next_auto_pend = 1'b0;
					next_dir = auto_neg ? hsc_pkg::DIR_NEG : hsc_pkg::DIR_POS;
					next_state = hsc_pkg::ST_SEEK_EOT;
					next_busy = 1'b1;
				end else if (accept && cmd.home) begin
					// Store flag is ignored: homing never goes to program memory
					next_dir = (cmd.dir_given && cmd.dir_neg) ? hsc_pkg::DIR_NEG
						: hsc_pkg::DIR_POS;
					next_state = hsc_pkg::ST_SEEK_EOT;
					next_busy = 1'b1;
				end else if (accept) begin
					if (extended && cmd.store) begin
						next_store.valid = 1'b1;
						next_store.clear_sel = cmd.clear_sel;
						next_store.words = hsc_pkg::STORE_WORDS;
					end else begin
						// Basic variant runs it now even if storing was asked
						next_pos_clear = clear_hit(cmd.clear_sel, hsc_pkg::CLR_POS_BIT);
						next_out_clear = clear_hit(cmd.clear_sel, hsc_pkg::CLR_OUT_BIT);
					end
				end
			end
			hsc_pkg::ST_SEEK_EOT: begin
				if (eot_low) begin
					next_dir = !dir;
					next_state = hsc_pkg::ST_SEEK_HOME;
				end else begin
					next_step = step_tick;
				end
			end
			hsc_pkg::ST_SEEK_HOME: begin
				// Tied switches end here at once, so no step after reversal
				if (home_low) begin
					next_state = hsc_pkg::ST_FINISH;
				end else begin
					next_step = step_tick;
				end
			end
			hsc_pkg::ST_FINISH: begin
				next_pos_clear = 1'b1;
				next_prog_clear = !extended;
				next_busy = 1'b0;
				next_state = hsc_pkg::ST_IDLE;
			end
		endcase
		// Strap is caught on the clocked recall pulse, never under reset;
		// placed last so a new recall wins over the pending flag being consumed
		if (prog_recalled) begin
			next_auto_pend = 1'b1;
			next_auto_neg = rxd_tied_high;
		end
	end

	// Sequencer registers
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			state <= hsc_pkg::ST_IDLE;
			busy <= 1'b0;
			step <= 1'b0;
			dir <= hsc_pkg::DIR_POS;
			pos_clear <= 1'b0;
			out_clear <= 1'b0;
			prog_clear <= 1'b0;
			store <= '0;
			auto_pend <= 1'b0;
			auto_neg <= 1'b0;
		end else begin
			state <= next_state;
			busy <= next_busy;
			step <= next_step;
			dir <= next_dir;
			pos_clear <= next_pos_clear;
			out_clear <= next_out_clear;
			prog_clear <= next_prog_clear;
			store <= next_store;
			auto_pend <= next_auto_pend;
			auto_neg <= next_auto_neg;
		end
	end

	// Checks on the sequencer
	a_default_dir_pos: assert property (@(posedge mclk) disable iff (!arst_n)
		accept && cmd.home && !cmd.dir_given |=> dir == hsc_pkg::DIR_POS)
		else $error("home without direction did not pick positive");
	a_step_on_tick: assert property (@(posedge mclk) disable iff (!arst_n)
		state == hsc_pkg::ST_SEEK_EOT && step_tick && !eot_low |=> step && busy)
		else $error("no step on tick while seeking end of travel");
	a_reverse_dir: assert property (@(posedge mclk) disable iff (!arst_n)
		state == hsc_pkg::ST_SEEK_EOT && eot_low
		|=> dir != $past(dir) && state == hsc_pkg::ST_SEEK_HOME)
		else $error("direction not reversed at end of travel");
	a_basic_clears: assert property (@(posedge mclk) disable iff (!arst_n)
		state == hsc_pkg::ST_FINISH && !extended |=> prog_clear && pos_clear && !busy)
		else $error("basic homing did not clear position and program");
	a_ext_keeps_prog: assert property (@(posedge mclk) disable iff (!arst_n)
		state == hsc_pkg::ST_FINISH && extended |=> pos_clear && !prog_clear)
		else $error("extended homing touched the program");
	a_tied_switches: assert property (@(posedge mclk) disable iff (!arst_n)
		state == hsc_pkg::ST_SEEK_EOT && eot_low && home_low
		|=> ##1 state == hsc_pkg::ST_FINISH && !step ##1 pos_clear)
		else $error("tied switches did not end homing at once");
	a_auto_home: assert property (@(posedge mclk) disable iff (!arst_n)
		prog_recalled && state == hsc_pkg::ST_IDLE ##1 state == hsc_pkg::ST_IDLE
		|=> state == hsc_pkg::ST_SEEK_EOT && dir == !$past(auto_neg))
		else $error("start-up homing not started with strapped direction");
	a_home_immediate: assert property (@(posedge mclk) disable iff (!arst_n)
		accept && cmd.home |=> state == hsc_pkg::ST_SEEK_EOT && !store.valid)
		else $error("home command not executed immediately");
	a_clear_select: assert property (@(posedge mclk) disable iff (!arst_n)
		accept && !cmd.home && !(extended && cmd.store)
		|=> pos_clear == $past(cmd.clear_sel[0]) && out_clear == $past(cmd.clear_sel[1]))
		else $error("selective clear hit the wrong targets");
	a_basic_no_store: assert property (@(posedge mclk) disable iff (!arst_n)
		accept && !cmd.home && !extended |=> !store.valid)
		else $error("basic variant stored a clear command");
	a_ext_store: assert property (@(posedge mclk) disable iff (!arst_n)
		accept && !cmd.home && extended && cmd.store
		|=> store.valid && store.words == hsc_pkg::STORE_WORDS && !pos_clear && !out_clear)
		else $error("stored clear wrong length or executed");
	a_sync_delay: assert property (@(posedge mclk) disable iff (!arst_n)
		$past(arst_n, 2) |-> sw_sync == $past({home_n, eot_n}, 2))
		else $error("switch levels not seen two cycles late");
	a_recall_sets: assert property (@(posedge mclk) disable iff (!arst_n)
		prog_recalled |=> auto_pend)
		else $error("program recall did not arm start-up homing");
	a_recall_blocks: assert property (@(posedge mclk) disable iff (!arst_n)
		prog_recalled && state == hsc_pkg::ST_IDLE |=> !cmd_ready ##1 busy)
		else $error("host command not held off during start-up homing");
	a_step_seek_home: assert property (@(posedge mclk) disable iff (!arst_n)
		state == hsc_pkg::ST_SEEK_HOME && step_tick && !home_low |=> step && busy)
		else $error("no step on tick while seeking home");
	a_no_stray_step: assert property (@(posedge mclk) disable iff (!arst_n)
		(state == hsc_pkg::ST_IDLE || state == hsc_pkg::ST_FINISH) |=> !step)
		else $error("step issued outside a search phase");
	a_dir_steady_eot: assert property (@(posedge mclk) disable iff (!arst_n)
		state == hsc_pkg::ST_SEEK_EOT && !eot_low |=> $stable(dir))
		else $error("direction changed before end of travel");
	a_dir_steady_home: assert property (@(posedge mclk) disable iff (!arst_n)
		state == hsc_pkg::ST_SEEK_HOME |=> $stable(dir))
		else $error("direction changed while seeking home");
endmodule

`default_nettype wire

// >>> verification/hsc_track.sv
// Partner model: end-of-travel and home switches on a track moved by steps
`timescale 1ns/1ps
`default_nettype none
module hsc_track #(parameter int LIM = 6, parameter int HOFF = 2) (
	input wire logic mclk,
	input wire logic step,
	input wire logic dir,
	input wire logic rearm,
	input wire logic [1:0] mode,
	output int pos,
	output logic eot_n,
	output logic home_n
);
	logic seen = 1'b0;
	// Track follows steps; rearm forgets the last end-of-travel hit
	always @(posedge mclk) begin
		if (step)
			pos <= dir ? pos + 1 : pos - 1;
		if (rearm)
			seen <= 1'b0;
		else if (!eot_n)
			seen <= 1'b1;
	end
	// Mode 1 ties the switches, mode 2 grounds both for standalone use
	always_comb begin
		eot_n = (mode != 2'h2) && !(pos >= LIM || pos <= -LIM);
		if (mode == 2'h2)
			home_n = 1'b0;
		else if (mode == 2'h1)
			home_n = eot_n;
		else
			home_n = !(seen && pos <= LIM - HOFF && pos >= HOFF - LIM);
	end
endmodule
`default_nettype wire

// >>> verification/testbench.sv
// Self-checking bench for the homing and selective clear logic
`timescale 1ns/1ps
`default_nettype none
module testbench;
	localparam int LIM = 6;
	localparam int HOFF = 2;
	logic mclk = 1'b0, arst_n = 1'b0, extended = 1'b0, cmd_valid = 1'b0, rearm = 1'b0;
	logic prog_recalled = 1'b0, rxd_tied_high = 1'b0, step_tick = 1'b0;
	logic cmd_ready, busy, step, dir, pos_clear, out_clear, prog_clear, eot_n, home_n;
	logic [1:0] mode = 2'h0, st_sel, st_words;
	logic [31:0] rng = 32'hB905;
	logic [31:0] rng_t = 32'hB905;
	hsc_pkg::hsc_cmd_type cmd = '0;
	hsc_pkg::hsc_store_type store;
	int pos, n_mismatch = 0, samples_checked = 0, cycles = 0, gap = 0;
	int n_pc = 0, n_oc = 0, n_gc = 0, n_st = 0;
	always #5 mclk = ~mclk;
	hsc_homing dut (.mclk(mclk), .arst_n(arst_n), .extended(extended), .cmd_valid(cmd_valid),
		.cmd_ready(cmd_ready), .cmd(cmd), .prog_recalled(prog_recalled),
		.rxd_tied_high(rxd_tied_high), .step_tick(step_tick), .eot_n(eot_n), .home_n(home_n),
		.busy(busy), .step(step), .dir(dir), .pos_clear(pos_clear), .out_clear(out_clear),
		.prog_clear(prog_clear), .store(store));
	hsc_track #(.LIM(LIM), .HOFF(HOFF)) trk (.mclk(mclk), .step(step), .dir(dir),
		.rearm(rearm), .mode(mode), .pos(pos), .eot_n(eot_n), .home_n(home_n));
	function automatic logic [31:0] xs(input logic [31:0] v);
		v ^= v << 13;
		v ^= v >> 17;
		return v ^ (v << 5);
	endfunction
	function automatic int end_pos(input logic neg, input logic [1:0] m, input int p);
		// Grounded switches, or a tied pair already pressed, home in place
		if (m == 2'h2 || (m == 2'h1 && (p >= LIM || p <= -LIM)))
			return p;
		return (neg ? -1 : 1) * ((m == 2'h1) ? LIM : LIM - HOFF);
	endfunction
	// Ticks kept sparse so switch latency never lets an extra step slip by
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (gap == 0) begin
			rng_t = xs(rng_t); // Own generator, so ticks do not race the stimulus
			gap <= 8 + int'(rng_t[2:0]);
		end else
			gap <= gap - 1;
		step_tick <= (gap == 1);
		n_pc <= n_pc + int'(pos_clear);
		n_oc <= n_oc + int'(out_clear);
		n_gc <= n_gc + int'(prog_clear);
		if (store.valid) begin
			n_st <= n_st + 1;
			{st_sel, st_words} <= {store.clear_sel, store.words};
		end
		if (cycles == 20000) begin
			n_mismatch++;
			wrap_up();
		end
	end
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch %s expected %0h seen %0h", what, exp, got);
		end
	endtask
	task automatic send(input hsc_pkg::hsc_cmd_type c);
		@(posedge mclk);
		cmd_valid <= 1'b1;
		cmd <= c;
		rearm <= 1'b1;
		@(negedge mclk);
		while (cmd_ready !== 1'b1)
			@(negedge mclk);
		@(posedge mclk);
		cmd_valid <= 1'b0;
		rearm <= 1'b0;
		@(negedge mclk);
	endtask
	task automatic wait_idle();
		while (busy !== 1'b0)
			@(negedge mclk);
		repeat (3) @(negedge mclk);
	endtask
	task automatic do_home(input logic given, input logic neg, input logic [1:0] m);
		int e, b_pc, b_gc;
		mode <= m;
		repeat (4) @(negedge mclk);
		e = end_pos(given && neg, m, pos);
		b_pc = n_pc;
		b_gc = n_gc;
		send('{home: 1'b1, dir_given: given, dir_neg: neg, clear_sel: 2'h0, store: 1'b1});
		chk("busy", 1, busy);
		chk("dir", !(given && neg), dir);
		wait_idle();
		chk("pos", e, pos);
		chk("pos_clear", 1, n_pc - b_pc);
		chk("prog_clear", !extended, n_gc - b_gc);
		chk("ready", 1, cmd_ready);
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// Clears cover every code, basic and extended, stored and immediate
	initial begin
		logic [1:0] sel;
		logic stored;
		int b_pc, b_oc, b_st;
		repeat (8) @(posedge mclk);
		arst_n <= 1'b1;
		for (int i = 0; i < 24; i++) begin
			rng = xs(rng);
			sel = (i < 4) ? 2'(i) : rng[1:0];
			stored = rng[3] && rng[2]; // Extended stores on request, zero argument too
			@(posedge mclk);
			extended <= rng[3];
			@(negedge mclk);
			{b_pc, b_oc, b_st} = {n_pc, n_oc, n_st};
			send('{home: 1'b0, dir_given: 1'b0, dir_neg: 1'b0, clear_sel: sel, store: rng[2]});
			repeat (2) @(negedge mclk);
			chk("pos_clear", !stored && sel[0], n_pc - b_pc);
			chk("out_clear", !stored && sel[1], n_oc - b_oc);
			chk("stores", stored, n_st - b_st);
			if (stored)
				chk("store", {sel, 2'h2}, {st_sel, st_words});
		end
		for (int h = 0; h < 6; h++) begin
			@(posedge mclk);
			extended <= h[0];
			do_home(h != 0, h[0], 2'(h / 2));
		end
		// Start-up homing for both strap levels
		mode = 2'h0;
		for (int s = 0; s < 2; s++) begin
			@(posedge mclk);
			{rearm, prog_recalled, rxd_tied_high} <= {2'h3, 1'(s)};
			@(posedge mclk);
			{rearm, prog_recalled} <= 2'h0;
			@(negedge mclk);
			chk("auto_ready", 0, cmd_ready);
			@(negedge mclk);
			chk("auto_busy", 1, busy);
			chk("auto_dir", s == 0, dir);
			wait_idle();
			chk("auto_pos", end_pos(s, 2'h0, 0), pos);
		end
		wrap_up();
	end
endmodule
`default_nettype wire
